// file: inc/fsq_consts.vh
// Purpose: Constants for the flash erase and program command sequencer.
// Assumes: One 10 MHz system clock; link pins sampled as plain inputs.
// Notes:   Times are in microseconds; cycle counts derive from the clock rate.
`ifndef FSQ_CONSTS_VH
`define FSQ_CONSTS_VH

// Opcodes
`define FSQ_OP_WR_ENABLE     8'h06
`define FSQ_OP_BLK32         8'h52
`define FSQ_OP_BLK32_WIDE    8'h5c
`define FSQ_OP_BLK64         8'hd8
`define FSQ_OP_BLK64_WIDE    8'hdc
`define FSQ_OP_FULL_A        8'h60
`define FSQ_OP_FULL_B        8'hc7
`define FSQ_OP_PAGE          8'h02
`define FSQ_OP_PAGE_WIDE     8'h12
`define FSQ_OP_PAGE_QD       8'h32
`define FSQ_OP_PAGE_QD_WIDE  8'h34
`define FSQ_OP_PAGE_QA       8'hc2

// Array geometry
`define FSQ_ARRAY_AW         25
`define FSQ_PAGE_BYTES       256
`define FSQ_BLK64_COUNT      10'h200

// Erase size codes on the array port
`define FSQ_ERASE_32K        2'h0
`define FSQ_ERASE_64K        2'h1
`define FSQ_ERASE_FULL       2'h2

// Self-timed cycle durations
`define FSQ_CLK_MHZ          10
`define FSQ_T_PAGE_US        250
`define FSQ_T_BLK32_US       100000
`define FSQ_T_BLK64_US       150000
`define FSQ_T_FULL_US        64000000
`define FSQ_PAGE_CYCLES      (`FSQ_T_PAGE_US * `FSQ_CLK_MHZ)
`define FSQ_BLK32_CYCLES     (`FSQ_T_BLK32_US * `FSQ_CLK_MHZ)
`define FSQ_BLK64_CYCLES     (`FSQ_T_BLK64_US * `FSQ_CLK_MHZ)
`define FSQ_FULL_CYCLES      (`FSQ_T_FULL_US * `FSQ_CLK_MHZ)

`endif

// file: rtl/fsq_buf.v
// Purpose: Two-entry buffer between the page drain and the array write port.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Full with two words; a stalled consumer stops the drain.
`timescale 1ns/10ps
`default_nettype none
module fsq_buf #(
   parameter WIDTH = 33
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] slot0;
   reg [WIDTH-1:0] slot1;
   reg [1:0]       fill;
   wire            push = in_valid & in_ready;
   wire            pop  = out_valid & out_ready;

   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data  = slot0;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         slot0 <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
         fill  <= 2'h0;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (fill == 2'h0) slot0 <= in_data;
               else slot1 <= in_data;
               fill <= fill + 2'h1;
            end
            2'b01: begin
               slot0 <= slot1;
               fill  <= fill - 2'h1;
            end
            2'b11: begin
               if (fill == 2'h1) begin
                  slot0 <= in_data;
               end else begin
                  slot0 <= slot1;
                  slot1 <= in_data;
               end
            end
            default: fill <= fill;
         endcase
      end
   end
endmodule // fsq_buf
`default_nettype wire

// file: rtl/fsq_timer.v
// Purpose: Down counter that times the self-timed erase and program cycles.
// Assumes: Start is a one-cycle pulse; load is at least one.
// Notes:   Done stays high while idle, so a finished drain need not wait.
`timescale 1ns/10ps
`default_nettype none
module fsq_timer (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Control
   input  wire        start,
   input  wire [31:0] load,
   output wire        done
);
   reg [31:0] count;
   reg        running;

   assign done = ~running;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count   <= 32'h0;
         running <= 1'b0;
      end else if (start) begin
         count   <= load;
         running <= 1'b1;
      end else if (running) begin
         count <= count - 32'h1;
         if (count <= 32'h1) running <= 1'b0;
      end
   end
endmodule // fsq_timer
`default_nettype wire

// file: rtl/fsq_top.v
// Purpose: Erase and page program command decode and write state of a serial NOR flash.
// Assumes: Link pins are synchronous to CLK; SCK runs well below CLK/2.
// Notes:   The array itself sits outside; erases and page bytes leave on ports.
`include "fsq_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module fsq_top #(
   parameter [31:0] BLK32_CYCLES = `FSQ_BLK32_CYCLES,
   parameter [31:0] BLK64_CYCLES = `FSQ_BLK64_CYCLES,
   parameter [31:0] FULL_CYCLES  = `FSQ_FULL_CYCLES
) (
   // Clock and reset
   input  wire        CLK,
   input  wire        RST,
   // Serial link
   input  wire        CS_N,
   input  wire        SCK,
   input  wire [3:0]  QUAD_DATA_LINES_IN,
   output wire [3:0]  QUAD_DATA_LINES_OUT,
   output wire [3:0]  QUAD_DATA_LINES_OE_N,
   // Configuration
   input  wire        ADDR4_MODE,
   input  wire        FOUR_LANE_COMMAND_MODE,
   input  wire [4:0]  BLOCK_PROTECT_BITS,
   // Status
   output wire        BUSY_STATUS_BIT,
   output wire        WRITE_ENABLE_LATCH,
   // Erase request to array
   output reg         ERASE_STB,
   output reg  [1:0]  ERASE_SIZE,
   output reg  [24:0] ERASE_ADDR,
   // Program stream to array
   output wire        PROG_VALID,
   input  wire        PROG_READY,
   output wire [24:0] PROG_ADDR,
   output wire [7:0]  PROG_DATA
);
   localparam [2:0] PH_OPC  = 3'h0;
   localparam [2:0] PH_ADDR = 3'h1;
   localparam [2:0] PH_DATA = 3'h2;
   localparam [2:0] PH_DONE = 3'h3;
   localparam [2:0] PH_BAD  = 3'h4;

   localparam [2:0] K_NONE  = 3'h0;
   localparam [2:0] K_WEN   = 3'h1;
   localparam [2:0] K_BLK32 = 3'h2;
   localparam [2:0] K_BLK64 = 3'h3;
   localparam [2:0] K_FULL  = 3'h4;
   localparam [2:0] K_PAGE  = 3'h5;

   localparam [1:0] B_IDLE  = 2'h0;
   localparam [1:0] B_DRAIN = 2'h1;
   localparam [1:0] B_WAIT  = 2'h2;

   // Protected range in 64K blocks: bit 4 picks bottom, low bits size it
   function prot_hit;
      input [8:0] blk;
      input [4:0] bp;
      reg   [9:0] n;
      begin
         n = 10'h0;
         if (bp[3:0] > 4'ha) n = `FSQ_BLK64_COUNT;
         else if (bp[3:0] != 4'h0) n = 10'h1 << (bp[3:0] - 4'h1);
         if (bp[4]) prot_hit = ({1'b0, blk} < n);
         else prot_hit = ({1'b0, blk} >= (`FSQ_BLK64_COUNT - n));
      end
   endfunction

   // Edge detection on the sampled link
   reg         sck_d;
   reg         cs_d;
   // Frame state
   reg  [2:0]  phase;
   reg  [2:0]  kind;
   reg         wide_addr;
   reg         quad_addr;
   reg         quad_data;
   reg  [7:0]  shreg;
   reg  [3:0]  bcnt;
   reg  [2:0]  abytes;
   reg  [31:0] addr;
   reg  [7:0]  offset;
   reg         got_data;
   // Page buffer
   reg  [7:0]  page_mem [0:255];
   reg  [255:0] page_ok;
   reg  [16:0] page_base;
   // Write state
   reg  [1:0]  bstate;
   reg  [8:0]  drain_idx;
   reg         write_enable_latch;
   reg         tm_start;
   reg  [31:0] tm_load;
   wire        tm_done;

   wire        idle     = (bstate == B_IDLE);
   wire        sck_rise = SCK & ~sck_d & ~CS_N & idle;
   wire        cs_fall  = ~CS_N & cs_d & idle;
   wire        cs_rise  = CS_N & ~cs_d;

   // Lane count per phase
   wire lanes4 = FOUR_LANE_COMMAND_MODE |
                 ((phase == PH_ADDR) & quad_addr) |
                 ((phase == PH_DATA) & quad_data);
   wire [3:0]  bcnt_nx  = bcnt + (lanes4 ? 4'h4 : 4'h1);
   wire [7:0]  sh_nx    = lanes4 ? {shreg[3:0], QUAD_DATA_LINES_IN} :
                                   {shreg[6:0], QUAD_DATA_LINES_IN[0]};
   wire        byte_end = (bcnt_nx == 4'h8);
   wire [2:0]  abytes_need = (wide_addr | ADDR4_MODE) ? 3'h4 : 3'h3;

   // Termination checks at chip select rising
   wire blk_ok   = (phase == PH_DONE) & ((kind == K_BLK32) | (kind == K_BLK64));
   wire full_ok  = (phase == PH_DONE) & (kind == K_FULL);
   wire page_end = (phase == PH_DATA) & (bcnt == 4'h0) & got_data;
   wire wen_ok   = (phase == PH_DONE) & (kind == K_WEN);
   wire addr_prot = prot_hit(addr[24:16], BLOCK_PROTECT_BITS);
   wire any_prot  = (BLOCK_PROTECT_BITS[3:0] != 4'h0);
   wire go_blk   = blk_ok & ~addr_prot;
   wire go_full  = full_ok & ~any_prot;
   wire go_page  = page_end & ~addr_prot;
   wire start    = idle & cs_rise & write_enable_latch & (go_blk | go_full | go_page);

   // Drain of the page buffer into the two-entry buffer
   wire        in_ready;
   wire        slot_ok  = page_ok[drain_idx[7:0]] & ~drain_idx[8];
   wire        in_valid = (bstate == B_DRAIN) & slot_ok;
   wire [32:0] in_word  = {page_base, drain_idx[7:0], page_mem[drain_idx[7:0]]};
   wire [32:0] out_word;

   assign QUAD_DATA_LINES_OUT  = 4'h0;
   assign QUAD_DATA_LINES_OE_N = 4'hf;
   assign BUSY_STATUS_BIT      = ~idle;
   assign WRITE_ENABLE_LATCH   = write_enable_latch;
   assign PROG_ADDR = out_word[32:8];
   assign PROG_DATA = out_word[7:0];

   // Serial frame collection
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         sck_d     <= 1'b0;
         cs_d      <= 1'b1;
         phase     <= PH_OPC;
         kind      <= K_NONE;
         wide_addr <= 1'b0;
         quad_addr <= 1'b0;
         quad_data <= 1'b0;
         shreg     <= 8'h0;
         bcnt      <= 4'h0;
         abytes    <= 3'h0;
         addr      <= 32'h0;
         offset    <= 8'h0;
         got_data  <= 1'b0;
         page_ok   <= 256'h0;
      end else begin
         sck_d <= SCK;
         cs_d  <= CS_N;
         if (cs_fall) begin
            phase    <= PH_OPC;
            kind     <= K_NONE;
            bcnt     <= 4'h0;
            abytes   <= 3'h0;
            // Stale upper bits would leak into 3-byte addresses
            addr     <= 32'h0;
            got_data <= 1'b0;
            page_ok  <= 256'h0;
         end else if (sck_rise) begin
            shreg <= sh_nx;
            bcnt  <= byte_end ? 4'h0 : bcnt_nx;
            if ((phase == PH_DONE) | (phase == PH_BAD)) begin
               phase <= PH_BAD;
            end else if (byte_end) begin
               case (phase)
                  PH_OPC: begin
                     wide_addr <= 1'b0;
                     quad_addr <= 1'b0;
                     quad_data <= 1'b0;
                     phase     <= PH_ADDR;
                     case (sh_nx)
                        `FSQ_OP_WR_ENABLE: begin
                           kind  <= K_WEN;
                           phase <= PH_DONE;
                        end
                        `FSQ_OP_BLK32:      kind <= K_BLK32;
                        `FSQ_OP_BLK32_WIDE: begin
                           kind      <= K_BLK32;
                           wide_addr <= 1'b1;
                        end
                        `FSQ_OP_BLK64:      kind <= K_BLK64;
                        `FSQ_OP_BLK64_WIDE: begin
                           kind      <= K_BLK64;
                           wide_addr <= 1'b1;
                        end
                        `FSQ_OP_FULL_A, `FSQ_OP_FULL_B: begin
                           kind  <= K_FULL;
                           phase <= PH_DONE;
                        end
                        `FSQ_OP_PAGE:       kind <= K_PAGE;
                        `FSQ_OP_PAGE_WIDE: begin
                           kind      <= K_PAGE;
                           wide_addr <= 1'b1;
                        end
                        `FSQ_OP_PAGE_QD: begin
                           kind      <= K_PAGE;
                           quad_data <= 1'b1;
                        end
                        `FSQ_OP_PAGE_QD_WIDE: begin
                           kind      <= K_PAGE;
                           quad_data <= 1'b1;
                           wide_addr <= 1'b1;
                        end
                        `FSQ_OP_PAGE_QA: begin
                           kind      <= K_PAGE;
                           quad_addr <= 1'b1;
                           quad_data <= 1'b1;
                        end
                        default: begin
                           kind  <= K_NONE;
                           phase <= PH_BAD;
                        end
                     endcase
                  end
                  PH_ADDR: begin
                     addr   <= {addr[23:0], sh_nx};
                     abytes <= abytes + 3'h1;
                     if (abytes + 3'h1 == abytes_need) begin
                        if (kind == K_PAGE) begin
                           phase  <= PH_DATA;
                           offset <= sh_nx;
                        end else begin
                           phase <= PH_DONE;
                        end
                     end
                  end
                  PH_DATA: begin
                     // Later bytes overwrite earlier ones at the same offset
                     page_ok[offset] <= 1'b1;
                     offset   <= offset + 8'h1;
                     got_data <= 1'b1;
                  end
                  default: phase <= PH_BAD;
               endcase
            end
         end else if (cs_rise) begin
            phase <= PH_OPC;
         end
      end
   end

   // Page storage has no reset: only slots marked in page_ok are drained
   always @(posedge CLK) begin
      if (sck_rise & byte_end & (phase == PH_DATA)) begin
         page_mem[offset] <= sh_nx;
      end
   end

   // Write state: latch, busy cycle and array requests
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         bstate     <= B_IDLE;
         drain_idx  <= 9'h0;
         write_enable_latch        <= 1'b0;
         tm_start   <= 1'b0;
         tm_load    <= 32'h1;
         page_base  <= 17'h0;
         ERASE_STB  <= 1'b0;
         ERASE_SIZE <= `FSQ_ERASE_32K;
         ERASE_ADDR <= 25'h0;
      end else begin
         tm_start  <= 1'b0;
         ERASE_STB <= 1'b0;
         case (bstate)
            B_IDLE: begin
               if (idle & cs_rise & wen_ok) begin
                  write_enable_latch <= 1'b1;
               end
               if (start) begin
                  tm_start <= 1'b1;
                  if (go_page) begin
                     bstate    <= B_DRAIN;
                     drain_idx <= 9'h0;
                     page_base <= addr[24:8];
                     tm_load   <= `FSQ_PAGE_CYCLES;
                  end else begin
                     bstate    <= B_WAIT;
                     ERASE_STB <= 1'b1;
                     if (go_full) begin
                        ERASE_SIZE <= `FSQ_ERASE_FULL;
                        ERASE_ADDR <= 25'h0;
                        tm_load    <= FULL_CYCLES;
                     end else if (kind == K_BLK64) begin
                        ERASE_SIZE <= `FSQ_ERASE_64K;
                        ERASE_ADDR <= {addr[24:16], 16'h0};
                        tm_load    <= BLK64_CYCLES;
                     end else begin
                        ERASE_SIZE <= `FSQ_ERASE_32K;
                        ERASE_ADDR <= {addr[24:15], 15'h0};
                        tm_load    <= BLK32_CYCLES;
                     end
                  end
               end
            end
            B_DRAIN: begin
               // Empty slots are skipped; a full buffer holds the index
               if (drain_idx[8]) bstate <= B_WAIT;
               else if (~slot_ok | in_ready) drain_idx <= drain_idx + 9'h1;
            end
            B_WAIT: begin
               if (tm_done & ~tm_start & ~PROG_VALID) begin
                  bstate <= B_IDLE;
                  write_enable_latch    <= 1'b0;
               end
            end
            default: bstate <= B_IDLE;
         endcase
      end
   end

   fsq_timer u_timer (
      .clk   (CLK),
      .rst   (RST),
      .start (tm_start),
      .load  (tm_load),
      .done  (tm_done)
   );

   fsq_buf #(
      .WIDTH (33)
   ) u_buf (
      .clk       (CLK),
      .rst       (RST),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (in_word),
      .out_valid (PROG_VALID),
      .out_ready (PROG_READY),
      .out_data  (out_word)
   );
endmodule // fsq_top
`default_nettype wire

// file: verif/fsq_chk_sva.sv
// Purpose: Port assertions for the erase and program sequencer.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Busy length bounds allow a little pipeline slack.
`include "fsq_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module fsq_chk #(
   parameter [31:0] BLK32_CYCLES = 32'd20,
   parameter [31:0] BLK64_CYCLES = 32'd30,
   parameter [31:0] FULL_CYCLES  = 32'd40
) (
   // Clock and link
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        CS_N,
   // Status and array ports
   input wire logic        BUSY_STATUS_BIT,
   input wire logic        WRITE_ENABLE_LATCH,
   input wire logic        ERASE_STB,
   input wire logic [1:0]  ERASE_SIZE,
   input wire logic [24:0] ERASE_ADDR,
   input wire logic        PROG_VALID,
   input wire logic        PROG_READY,
   input wire logic [24:0] PROG_ADDR,
   input wire logic [7:0]  PROG_DATA
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (RST);
   logic [31:0] busy_cnt;
   logic [31:0] need;
   logic        is_erase;
   // Page cycle stretches with array stalls, so only erases get an upper bound
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         busy_cnt <= 32'h0;
         need     <= 32'h0;
         is_erase <= 1'b0;
      end else begin
         busy_cnt <= BUSY_STATUS_BIT ? busy_cnt + 32'h1 : 32'h0;
         if (ERASE_STB) begin
            is_erase <= 1'b1;
            need     <= (ERASE_SIZE == 2'h0) ? BLK32_CYCLES :
                        (ERASE_SIZE == 2'h1) ? BLK64_CYCLES : FULL_CYCLES;
         end else if ($rose(BUSY_STATUS_BIT)) begin
            is_erase <= 1'b0;
            need     <= `FSQ_PAGE_CYCLES;
         end
      end
   end
   sequence cs_close;
      !CS_N ##1 CS_N;
   endsequence
   busy_cause_a: assert property (
      $rose(BUSY_STATUS_BIT) |-> $past(CS_N) && $past(WRITE_ENABLE_LATCH))
      else $error("busy rose without frame close and latch");
   no_latch_idle_a: assert property (
      (!WRITE_ENABLE_LATCH throughout cs_close) |=> !BUSY_STATUS_BIT)
      else $error("busy started with latch clear");
   latch_clear_a: assert property (
      $fell(BUSY_STATUS_BIT) |-> !WRITE_ENABLE_LATCH)
      else $error("latch still set after busy");
   busy_latch_a: assert property (
      BUSY_STATUS_BIT |-> WRITE_ENABLE_LATCH)
      else $error("busy while latch clear");
   stb_pulse_a: assert property (
      ERASE_STB |-> $rose(BUSY_STATUS_BIT) ##1 !ERASE_STB)
      else $error("erase strobe not a pulse at busy start");
   blk32_align_a: assert property (
      ERASE_STB && ERASE_SIZE == 2'h0 |-> ERASE_ADDR[14:0] == 15'h0)
      else $error("32K erase address not aligned");
   blk64_align_a: assert property (
      ERASE_STB && ERASE_SIZE == 2'h1 |-> ERASE_ADDR[15:0] == 16'h0)
      else $error("64K erase address not aligned");
   full_addr_a: assert property (
      ERASE_STB && ERASE_SIZE == 2'h2 |-> ERASE_ADDR == 25'h0)
      else $error("full erase address not zero");
   prog_hold_a: assert property (
      PROG_VALID && !PROG_READY |=> PROG_VALID && $stable(PROG_ADDR) && $stable(PROG_DATA))
      else $error("program word changed while stalled");
   prog_busy_a: assert property (
      PROG_VALID |-> BUSY_STATUS_BIT)
      else $error("program word outside busy");
   busy_len_a: assert property (
      $fell(BUSY_STATUS_BIT) |-> busy_cnt + 32'h2 >= need && (!is_erase || busy_cnt <= need + 32'h8))
      else $error("busy length out of bounds");
endmodule // fsq_chk
bind fsq_top fsq_chk #(
   .BLK32_CYCLES(BLK32_CYCLES),
   .BLK64_CYCLES(BLK64_CYCLES),
   .FULL_CYCLES (FULL_CYCLES)
) u_chk (.CLK(CLK), .RST(RST), .CS_N(CS_N), .BUSY_STATUS_BIT(BUSY_STATUS_BIT),
   .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .ERASE_STB(ERASE_STB), .ERASE_SIZE(ERASE_SIZE),
   .ERASE_ADDR(ERASE_ADDR), .PROG_VALID(PROG_VALID), .PROG_READY(PROG_READY),
   .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA));
`default_nettype wire

// file: verif/fsq_host.sv
// Purpose: Host controller model driving the serial link.
// Assumes: Driven on the falling CLK edge; SCK phases last two CLK periods.
// Notes:   SCK rests low between frames; idle data lines toggle every cycle.
`timescale 1ns/10ps
`default_nettype none
module fsq_host (
   // Clock
   input  wire logic       clk,
   // Link
   output var  logic       cs_n,
   output var  logic       sck,
   output wire logic [3:0] dq
);
   logic       sel;
   logic [3:0] dq_tx;
   logic [3:0] idle;
   initial begin
      cs_n  = 1'b1;
      sck   = 1'b0;
      sel   = 1'b0;
      dq_tx = 4'h0;
      idle  = 4'h5;
   end
   always @(negedge clk) idle <= ~idle;
   assign dq = sel ? dq_tx : idle;
   task automatic start;
      @(negedge clk);
      cs_n = 1'b0;
      sel  = 1'b1;
   endtask
   // Count is shift clocks: 8 single-lane or 2 four-lane for a whole byte
   task automatic put(input logic [7:0] b, input bit quad, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         @(negedge clk);
         sck   = 1'b0;
         dq_tx = quad ? (i[0] ? b[3:0] : b[7:4]) : {3'h0, b[7-i]};
         repeat (2) @(negedge clk);
         sck = 1'b1;
         @(negedge clk);
      end
   endtask
   task automatic stop;
      @(negedge clk);
      sck = 1'b0;
      repeat (2) @(negedge clk);
      cs_n = 1'b1;
      sel  = 1'b0;
      repeat (2) @(negedge clk);
   endtask
endmodule // fsq_host
`default_nettype wire

// file: verif/tb.sv
// Purpose: Self-checking bench for the erase and program sequencer.
// Assumes: Host model drives the link; the bench plays the array side.
// Notes:   Erase times are shortened by parameter to keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk;
   logic        rst;
   logic        addr4;
   logic        four;
   logic [4:0]  bp;
   logic        prog_ready;
   wire         cs_n;
   wire         sck;
   wire  [3:0]  dq;
   wire  [3:0]  dq_out;
   wire  [3:0]  dq_oe_n;
   wire         busy;
   wire         write_enable_latch;
   wire         stb;
   wire  [1:0]  esize;
   wire  [24:0] eaddr;
   wire         pvalid;
   wire  [24:0] paddr;
   wire  [7:0]  pdata;
   integer      seed;
   int          error_cnt;
   int          total_checks;
   int          cyc;
   int          stb_cnt;
   logic [1:0]  stb_size;
   logic [24:0] stb_addr;
   logic [24:0] got_a [$];
   logic [7:0]  got_d [$];
   logic [7:0]  op_e [6] = '{8'h52, 8'h5c, 8'hd8, 8'hdc, 8'h60, 8'hc7};
   logic [7:0]  op_p [5] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'hc2};
   fsq_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .dq(dq));
   fsq_top #(.BLK32_CYCLES(32'd20), .BLK64_CYCLES(32'd30), .FULL_CYCLES(32'd40)) DUT (
      .CLK(clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .QUAD_DATA_LINES_IN(dq),
      .QUAD_DATA_LINES_OUT(dq_out), .QUAD_DATA_LINES_OE_N(dq_oe_n), .ADDR4_MODE(addr4),
      .FOUR_LANE_COMMAND_MODE(four), .BLOCK_PROTECT_BITS(bp), .BUSY_STATUS_BIT(busy),
      .WRITE_ENABLE_LATCH(write_enable_latch), .ERASE_STB(stb), .ERASE_SIZE(esize), .ERASE_ADDR(eaddr),
      .PROG_VALID(pvalid), .PROG_READY(prog_ready), .PROG_ADDR(paddr), .PROG_DATA(pdata));
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pvalid === 1'b1 && prog_ready === 1'b1) begin
         got_a.push_back(paddr);
         got_d.push_back(pdata);
      end
      if (stb === 1'b1) begin
         stb_cnt  <= stb_cnt + 1;
         stb_size <= esize;
         stb_addr <= eaddr;
      end
   end
   // Random stalls from the array side exercise the two-entry buffer
   always @(negedge clk) begin
      prog_ready <= ($random(seed) & 3) != 0;
      if (cyc > 90000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic run(input logic [7:0] op, input logic [31:0] a, input int ndat,
                      input bit extra, input bit we, input bit ok);
      int          nab;
      int          s0;
      int          n;
      bit          qa;
      bit          qd;
      bit          prog;
      logic [1:0]  sz;
      logic [24:0] ea;
      logic [7:0]  ev [256];
      bit          es [256];
      prog = op inside {8'h02, 8'h12, 8'h32, 8'h34, 8'hc2};
      nab  = (op inside {8'h60, 8'hc7}) ? 0 :
             (addr4 || op inside {8'h5c, 8'hdc, 8'h12, 8'h34}) ? 4 : 3;
      qa   = four || op == 8'hc2;
      qd   = four || op inside {8'h32, 8'h34, 8'hc2};
      sz   = (op inside {8'h52, 8'h5c}) ? 2'h0 : (op inside {8'hd8, 8'hdc}) ? 2'h1 : 2'h2;
      ea   = (nab == 4) ? a[24:0] : {1'b0, a[23:0]};
      s0   = stb_cnt;
      got_a.delete();
      got_d.delete();
      if (we) begin
         host.start();
         host.put(8'h06, four, four ? 2 : 8);
         host.stop();
         check(write_enable_latch, 1'b1);
      end
      host.start();
      host.put(op, four, four ? 2 : 8);
      for (int i = nab - 1; i >= 0; i--) host.put(a[8*i +: 8], qa, qa ? 2 : 8);
      for (int i = 0; i < ndat; i++) begin
         tx_byte(ev, es, (ea[7:0] + i) % 256, qd);
      end
      if (extra) host.put(8'hff, qd, 1);
      host.stop();
      repeat (2) @(negedge clk);
      check(busy, ok);
      for (n = 0; n < 6000 && busy !== 1'b0; n++) @(negedge clk);
      check(write_enable_latch, we && !ok);
      check(stb_cnt - s0, ok && !prog);
      if (ok && !prog) begin
         check(stb_size, sz);
         check(stb_addr, sz == 2'h0 ? ea & 25'h1ff8000 : sz == 2'h1 ? ea & 25'h1ff0000 : 25'h0);
      end
      n = 0;
      foreach (es[k]) n += es[k];
      check(got_a.size(), (prog && ok) ? n : 0);
      foreach (got_a[k]) begin
         check(got_a[k][24:8], ea[24:8]);
         check(got_d[k], ev[got_a[k][7:0]]);
      end
      $display("op %h ok=%0d done t=%0t", op, ok, $time);
   endtask
   // Later bytes at the same offset replace earlier ones
   task automatic tx_byte(inout logic [7:0] ev [256], inout bit es [256], input int off,
                          input bit qd);
      logic [7:0] b;
      b       = $random(seed);
      ev[off] = b;
      es[off] = 1'b1;
      host.put(b, qd, qd ? 2 : 8);
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      addr4 = 1'b0;
      four = 1'b0;
      bp = 5'h00;
      prog_ready = 1'b1;
      seed = 32'hbe9d;
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      stb_cnt = 0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      check(busy, 1'b0);
      check(write_enable_latch, 1'b0);
      check(dq_oe_n, 4'hf);
      check(dq_out, 4'h0);
      run(8'hd8, 32'h0012_3456, 0, 0, 0, 0);
      for (int k = 0; k < 6; k++) begin
         four  = k[0];
         addr4 = k[1];
         // Individual protect is never selected, so no unlock precedes a full erase
         run(op_e[k], $random(seed), 0, 0, 1, 1);
      end
      bp = 5'h11;
      run(8'h52, 32'h0000_8000, 0, 0, 1, 0);
      run(8'hdc, 32'h0009_0000, 0, 0, 1, 1);
      run(8'hc7, 32'h0, 0, 0, 1, 0);
      run(8'h02, 32'h0000_0100, 3, 0, 1, 0);
      bp = 5'h00;
      run(8'hd8, 32'h0005_0000, 0, 1, 1, 0);
      run(8'h02, 32'h0003_0200, 0, 0, 1, 0);
      run(8'h12, 32'h0003_0200, 4, 1, 1, 0);
      run(8'h77, 32'h0001_0000, 0, 0, 1, 0);
      for (int k = 0; k < 5; k++) begin
         four  = k == 4;
         addr4 = $random(seed);
         run(op_p[k], $random(seed) | 32'hf0, 1 + {$random(seed)} % 40, 0, 1, 1);
      end
      four = 1'b1;
      run(8'h02, 32'h0004_01fa, 260, 0, 1, 1);
      run(8'h02, 32'h0006_0000, 256, 0, 1, 1);
      print_verdict();
   end
endmodule // tb
`default_nettype wire
